/* File: verilog/actu_pkg.sv */
// constants, field layouts and types for the adc compute and threshold unit
package actu_pkg;

  // =====================================================================
  // register byte addresses
  localparam logic [11:0] ACTU_ADR_TRIG_SRC = 12'hF51;
  localparam logic [11:0] ACTU_ADR_CLK_DIV = 12'hF52;
  localparam logic [11:0] ACTU_ADR_REF_SEL = 12'hF53;
  localparam logic [11:0] ACTU_ADR_SAMP_CTL1 = 12'hF54;
  localparam logic [11:0] ACTU_ADR_COMP_CTL = 12'hF55;
  localparam logic [11:0] ACTU_ADR_THR_CTL = 12'hF56;
  localparam logic [11:0] ACTU_ADR_ACQ_TIME = 12'hF57;
  localparam logic [11:0] ACTU_ADR_EXTRA_CAP = 12'hF58;
  localparam logic [11:0] ACTU_ADR_PRE_TIME = 12'hF59;
  localparam logic [11:0] ACTU_ADR_CHAN_SEL = 12'hF5A;
  localparam logic [11:0] ACTU_ADR_MAIN_CTL = 12'hF5B;
  localparam logic [11:0] ACTU_ADR_PREV_L = 12'hF5C;
  localparam logic [11:0] ACTU_ADR_PREV_H = 12'hF5D;
  localparam logic [11:0] ACTU_ADR_RES_L = 12'hF5E;
  localparam logic [11:0] ACTU_ADR_RES_H = 12'hF5F;
  localparam logic [11:0] ACTU_ADR_STATUS = 12'hF60;
  localparam logic [11:0] ACTU_ADR_RPT = 12'hF61;
  localparam logic [11:0] ACTU_ADR_CNT = 12'hF62;
  localparam logic [11:0] ACTU_ADR_STPT_L = 12'hF63;
  localparam logic [11:0] ACTU_ADR_STPT_H = 12'hF64;
  localparam logic [11:0] ACTU_ADR_LTH_L = 12'hF65;
  localparam logic [11:0] ACTU_ADR_LTH_H = 12'hF66;
  localparam logic [11:0] ACTU_ADR_UTH_L = 12'hF67;
  localparam logic [11:0] ACTU_ADR_UTH_H = 12'hF68;
  localparam logic [11:0] ACTU_ADR_ERR_L = 12'hF69;
  localparam logic [11:0] ACTU_ADR_ERR_H = 12'hF6A;
  localparam logic [11:0] ACTU_ADR_ACC_L = 12'hF6B;
  localparam logic [11:0] ACTU_ADR_ACC_H = 12'hF6C;
  localparam logic [11:0] ACTU_ADR_FLT_L = 12'hF6D;
  localparam logic [11:0] ACTU_ADR_FLT_H = 12'hF6E;
  localparam logic [11:0] ACTU_ADR_IRQ_FLAG = 12'hF6F;

  // =====================================================================
  // field positions
  localparam int ACTU_MAIN_ON = 7;
  localparam int ACTU_MAIN_CONT = 6;
  localparam int ACTU_MAIN_FM = 2;
  localparam int ACTU_MAIN_GO = 0;
  localparam int ACTU_S1_DSEN = 0;
  localparam int ACTU_COMP_PSIS = 7;
  localparam int ACTU_COMP_CRS_HI = 6;
  localparam int ACTU_COMP_CRS_LO = 4;
  localparam int ACTU_COMP_ACLR = 3;
  localparam int ACTU_COMP_MD_HI = 2;
  localparam int ACTU_COMP_MD_LO = 0;
  localparam int ACTU_THR_CALC_HI = 6;
  localparam int ACTU_THR_CALC_LO = 4;
  localparam int ACTU_THR_SOI = 3;
  localparam int ACTU_THR_TMD_HI = 2;
  localparam int ACTU_THR_TMD_LO = 0;
  localparam int ACTU_STAT_MATH = 4;
  localparam int ACTU_FLAG_TIF = 0;

  // =====================================================================
  // widths and reset values
  localparam int ACTU_RAW_W = 10;
  localparam int ACTU_PAD_W = 6;
  localparam logic [7:0] ACTU_RST_BYTE = 8'h00;
  localparam logic [15:0] ACTU_RST_WORD = 16'h0000;
  localparam logic [7:0] ACTU_CNT_MAX = 8'hFF;
  localparam logic [7:0] ACTU_CNT_ONE = 8'h01;
  localparam logic [1:0] ACTU_STAT_PAD = 2'h0;

  // =====================================================================
  // operating modes
  localparam logic [2:0] ACTU_MD_BASIC = 3'h0;
  localparam logic [2:0] ACTU_MD_ACCUM = 3'h1;
  localparam logic [2:0] ACTU_MD_AVG = 3'h2;
  localparam logic [2:0] ACTU_MD_BURST = 3'h3;
  localparam logic [2:0] ACTU_MD_LPF = 3'h4;

  // error calculation codes
  localparam logic [2:0] ACTU_CALC_FLT = 3'h7;
  localparam logic [2:0] ACTU_CALC_RES = 3'h6;
  localparam logic [2:0] ACTU_CALC_FLT_STPT = 3'h5;
  localparam logic [2:0] ACTU_CALC_PREV_FLT = 3'h4;
  localparam logic [2:0] ACTU_CALC_RES_FLT = 3'h2;
  localparam logic [2:0] ACTU_CALC_RES_STPT = 3'h1;
  localparam logic [2:0] ACTU_CALC_RES_PREV = 3'h0;

  // threshold conditions
  localparam logic [2:0] ACTU_TMD_NEVER = 3'h0;
  localparam logic [2:0] ACTU_TMD_BELOW_LO = 3'h1;
  localparam logic [2:0] ACTU_TMD_ATLEAST_LO = 3'h2;
  localparam logic [2:0] ACTU_TMD_INSIDE = 3'h3;
  localparam logic [2:0] ACTU_TMD_OUTSIDE = 3'h4;
  localparam logic [2:0] ACTU_TMD_ATMOST_UP = 3'h5;
  localparam logic [2:0] ACTU_TMD_ABOVE_UP = 3'h6;
  localparam logic [2:0] ACTU_TMD_ALWAYS = 3'h7;

  // =====================================================================
  // sequencer states and the state record
  typedef enum logic [1:0] {
    ACTU_ST_IDLE = 2'b01,
    ACTU_ST_CONV = 2'b10
  } actu_state_t;

  typedef struct packed {
    logic [7:0] trig_src;
    logic [7:0] clk_div;
    logic [7:0] ref_sel;
    logic [7:0] samp_ctl1;
    logic [7:0] comp_ctl;
    logic [7:0] thr_ctl;
    logic [7:0] acq_time;
    logic [7:0] extra_cap;
    logic [7:0] pre_time;
    logic [7:0] chan_sel;
    logic [7:0] main_ctl;
    logic [7:0] rpt;
    logic [7:0] cnt;
    logic [15:0] prev;
    logic [15:0] res;
    logic [15:0] stpt;
    logic [15:0] lth;
    logic [15:0] uth;
    logic [15:0] err;
    logic [15:0] acc;
    logic [15:0] flt;
    logic aov;
    logic uthr;
    logic lthr;
    logic math;
    logic tif;
    logic pair_second;
    actu_state_t state;
    logic [7:0] rd_data;
    logic conv_start;
  } actu_regs_t;

endpackage : actu_pkg

/* File: verilog/actu_top.sv */
// computation, filtering and threshold logic behind the converter core
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - average mode accumulates and counts every sample except the first of a double-sampled pair
// - average mode refreshes filtered output by shift
// - average mode tests only when count reaches target
// - burst mode retriggers until count reaches target
// - low-pass mode filters, cutoff by shift, tests
// - results latched and held from end-of-conversion
// - error source chosen by calculation select
// - codes 010/001 use difference when double sampling
// - thresholds compared, upper and lower flags updated
// - threshold mode picks one of eight conditions
// - met condition sets threshold interrupt flag
// - error and thresholds compared as signed
// - accumulator overflow forces threshold interrupt
// - continuous mode restarts until reset or stop
// - double sampling needs two separately started conversions unless continuous mode restarts the second
// - first of pair flags, updates, no error
// - second of pair shifts results, then computes
// - sum beyond 65535 sets overflow flag
// - clear command empties accumulator, flag, counter
// - previous result loaded at start per select
// - sample counter saturates at FF
module actu_top
  import actu_pkg::*;
(
  input wire logic i_clk,                  // 50 MHz system clock
  input wire logic i_reset_n,              // synchronous reset, active low
  input wire logic [11:0] i_addr,          // register byte address
  input wire logic [7:0] i_wr_data,        // register write data
  input wire logic i_wr_en,                // write strobe
  input wire logic i_rd_en,                // read strobe
  input wire logic i_trigger,              // external start pulse
  input wire logic i_conv_done,            // core end-of-conversion pulse
  input wire logic [9:0] i_conv_result,    // core raw result
  output logic [7:0] o_rd_data,            // read data, cycle after strobe
  output logic o_conv_start,               // one-cycle start to the core
  output logic o_conv_busy,                // conversion go bit
  output logic [7:0] o_channel,            // channel select to the core
  output logic o_threshold_flag,           // threshold interrupt flag
  output logic o_overflow_flag             // accumulator overflow flag
);

  // =====================================================================
  // helper functions

  // place the raw result right or left justified in a 16-bit word
  function automatic logic [15:0] actu_format(input logic right,
                                              input logic [9:0] raw);
    if (right) begin
      actu_format = {{ACTU_PAD_W{1'b0}}, raw};
    end else begin
      actu_format = {raw, {ACTU_PAD_W{1'b0}}};
    end
  endfunction : actu_format

  // one accumulator step; bit 16 flags a sum outside 0..65535
  function automatic logic [16:0] actu_acc_step(input logic [15:0] acc,
                                                input logic [15:0] smp,
                                                input logic smp_signed,
                                                input logic lpf,
                                                input logic [2:0] crs);
    logic [16:0] ext;
    logic [16:0] decay;
    ext = {smp_signed & smp[15], smp};
    decay = lpf ? {1'b0, acc >> crs} : 17'h00000;
    actu_acc_step = {1'b0, acc} + ext - decay;
  endfunction : actu_acc_step

  // error value selected by the calculation code, two's complement
  function automatic logic [15:0] actu_error(input logic [2:0] calc,
                                             input logic dsen,
                                             input logic [15:0] res,
                                             input logic [15:0] prev,
                                             input logic [15:0] flt,
                                             input logic [15:0] stpt);
    logic [15:0] base;
    base = dsen ? res - prev : res;
    case (calc)
      ACTU_CALC_FLT: actu_error = flt;
      ACTU_CALC_RES: actu_error = res;
      ACTU_CALC_FLT_STPT: actu_error = flt - stpt;
      ACTU_CALC_PREV_FLT: actu_error = prev - flt;
      ACTU_CALC_RES_FLT: actu_error = base - flt;
      ACTU_CALC_RES_STPT: actu_error = base - stpt;
      ACTU_CALC_RES_PREV: actu_error = res - prev;
      default: actu_error = ACTU_RST_WORD;          // reserved code
    endcase
  endfunction : actu_error

  // selected threshold condition on signed operands
  function automatic logic actu_thr_met(input logic [2:0] tmd,
                                        input logic signed [15:0] err,
                                        input logic signed [15:0] lth,
                                        input logic signed [15:0] uth);
    case (tmd)
      ACTU_TMD_NEVER: actu_thr_met = 1'b0;
      ACTU_TMD_BELOW_LO: actu_thr_met = err < lth;
      ACTU_TMD_ATLEAST_LO: actu_thr_met = err >= lth;
      ACTU_TMD_INSIDE: actu_thr_met = (err >= lth) && (err <= uth);
      ACTU_TMD_OUTSIDE: actu_thr_met = (err < lth) || (err > uth);
      ACTU_TMD_ATMOST_UP: actu_thr_met = err <= uth;
      ACTU_TMD_ABOVE_UP: actu_thr_met = err > uth;
      default: actu_thr_met = 1'b1;                 // always
    endcase
  endfunction : actu_thr_met

  // =====================================================================
  // state record
  actu_regs_t r_reg;
  actu_regs_t r_next;

  // field views of the control registers
  logic [2:0] mode;
  logic [2:0] crs;
  logic [2:0] calc;
  logic [2:0] tmd;
  logic dsen;
  logic cont;
  logic soi;
  assign mode = r_reg.comp_ctl[ACTU_COMP_MD_HI:ACTU_COMP_MD_LO];
  assign crs = r_reg.comp_ctl[ACTU_COMP_CRS_HI:ACTU_COMP_CRS_LO];
  assign calc = r_reg.thr_ctl[ACTU_THR_CALC_HI:ACTU_THR_CALC_LO];
  assign tmd = r_reg.thr_ctl[ACTU_THR_TMD_HI:ACTU_THR_TMD_LO];
  assign dsen = r_reg.samp_ctl1[ACTU_S1_DSEN];
  assign cont = r_reg.main_ctl[ACTU_MAIN_CONT];
  assign soi = r_reg.thr_ctl[ACTU_THR_SOI];

  // =====================================================================
  // next-state logic: bus, sequencer and computation
  always_comb begin
    logic do_start;
    logic hw_retrig;
    logic go_again;
    logic test_now;
    logic [15:0] smp;
    logic [15:0] term;
    logic [16:0] sum;
    do_start = 1'b0;
    hw_retrig = 1'b0;
    go_again = 1'b0;
    test_now = 1'b0;
    smp = actu_format(r_reg.main_ctl[ACTU_MAIN_FM], i_conv_result);
    term = smp;
    sum = 17'h00000;
    r_next = r_reg;
    r_next.conv_start = 1'b0;
    r_next.rd_data = ACTU_RST_BYTE;

    // read path; unmapped addresses read as zero
    if (i_rd_en) begin
      case (i_addr)
        ACTU_ADR_TRIG_SRC: r_next.rd_data = r_reg.trig_src;
        ACTU_ADR_CLK_DIV: r_next.rd_data = r_reg.clk_div;
        ACTU_ADR_REF_SEL: r_next.rd_data = r_reg.ref_sel;
        ACTU_ADR_SAMP_CTL1: r_next.rd_data = r_reg.samp_ctl1;
        ACTU_ADR_COMP_CTL: r_next.rd_data = r_reg.comp_ctl;
        ACTU_ADR_THR_CTL: r_next.rd_data = r_reg.thr_ctl;
        ACTU_ADR_ACQ_TIME: r_next.rd_data = r_reg.acq_time;
        ACTU_ADR_EXTRA_CAP: r_next.rd_data = r_reg.extra_cap;
        ACTU_ADR_PRE_TIME: r_next.rd_data = r_reg.pre_time;
        ACTU_ADR_CHAN_SEL: r_next.rd_data = r_reg.chan_sel;
        ACTU_ADR_MAIN_CTL: r_next.rd_data = r_reg.main_ctl;
        ACTU_ADR_PREV_L: r_next.rd_data = r_reg.prev[7:0];
        ACTU_ADR_PREV_H: r_next.rd_data = r_reg.prev[15:8];
        ACTU_ADR_RES_L: r_next.rd_data = r_reg.res[7:0];
        ACTU_ADR_RES_H: r_next.rd_data = r_reg.res[15:8];
        ACTU_ADR_STATUS: r_next.rd_data = {r_reg.aov, r_reg.uthr,
                                           r_reg.lthr, r_reg.math,
                                           ACTU_STAT_PAD, r_reg.state};
        ACTU_ADR_RPT: r_next.rd_data = r_reg.rpt;
        ACTU_ADR_CNT: r_next.rd_data = r_reg.cnt;
        ACTU_ADR_STPT_L: r_next.rd_data = r_reg.stpt[7:0];
        ACTU_ADR_STPT_H: r_next.rd_data = r_reg.stpt[15:8];
        ACTU_ADR_LTH_L: r_next.rd_data = r_reg.lth[7:0];
        ACTU_ADR_LTH_H: r_next.rd_data = r_reg.lth[15:8];
        ACTU_ADR_UTH_L: r_next.rd_data = r_reg.uth[7:0];
        ACTU_ADR_UTH_H: r_next.rd_data = r_reg.uth[15:8];
        ACTU_ADR_ERR_L: r_next.rd_data = r_reg.err[7:0];
        ACTU_ADR_ERR_H: r_next.rd_data = r_reg.err[15:8];
        ACTU_ADR_ACC_L: r_next.rd_data = r_reg.acc[7:0];
        ACTU_ADR_ACC_H: r_next.rd_data = r_reg.acc[15:8];
        ACTU_ADR_FLT_L: r_next.rd_data = r_reg.flt[7:0];
        ACTU_ADR_FLT_H: r_next.rd_data = r_reg.flt[15:8];
        ACTU_ADR_IRQ_FLAG: r_next.rd_data = {7'h00, r_reg.tif};
        default: r_next.rd_data = ACTU_RST_BYTE;
      endcase
    end

    // write path; read-only registers ignore writes
    if (i_wr_en) begin
      case (i_addr)
        ACTU_ADR_TRIG_SRC: r_next.trig_src = i_wr_data;
        ACTU_ADR_CLK_DIV: r_next.clk_div = i_wr_data;
        ACTU_ADR_REF_SEL: r_next.ref_sel = i_wr_data;
        ACTU_ADR_SAMP_CTL1: r_next.samp_ctl1 = i_wr_data;
        ACTU_ADR_COMP_CTL: begin
          r_next.comp_ctl = i_wr_data;
          // a pending clear is not cancelled by a later zero
          r_next.comp_ctl[ACTU_COMP_ACLR] = r_reg.comp_ctl[ACTU_COMP_ACLR]
                                          | i_wr_data[ACTU_COMP_ACLR];
        end
        ACTU_ADR_THR_CTL: r_next.thr_ctl = i_wr_data;
        ACTU_ADR_ACQ_TIME: r_next.acq_time = i_wr_data;
        ACTU_ADR_EXTRA_CAP: r_next.extra_cap = i_wr_data;
        ACTU_ADR_PRE_TIME: r_next.pre_time = i_wr_data;
        ACTU_ADR_CHAN_SEL: r_next.chan_sel = i_wr_data;
        ACTU_ADR_MAIN_CTL: r_next.main_ctl = i_wr_data;
        ACTU_ADR_STATUS: begin
          if (!i_wr_data[ACTU_STAT_MATH]) begin
            r_next.math = 1'b0;                // hardware set below wins
          end
        end
        ACTU_ADR_RPT: r_next.rpt = i_wr_data;
        ACTU_ADR_CNT: r_next.cnt = i_wr_data;
        ACTU_ADR_STPT_L: r_next.stpt[7:0] = i_wr_data;
        ACTU_ADR_STPT_H: r_next.stpt[15:8] = i_wr_data;
        ACTU_ADR_LTH_L: r_next.lth[7:0] = i_wr_data;
        ACTU_ADR_LTH_H: r_next.lth[15:8] = i_wr_data;
        ACTU_ADR_UTH_L: r_next.uth[7:0] = i_wr_data;
        ACTU_ADR_UTH_H: r_next.uth[15:8] = i_wr_data;
        ACTU_ADR_ACC_L: r_next.acc[7:0] = i_wr_data;
        ACTU_ADR_ACC_H: r_next.acc[15:8] = i_wr_data;
        ACTU_ADR_IRQ_FLAG: begin
          if (i_wr_data[ACTU_FLAG_TIF]) begin
            r_next.tif = 1'b0;                 // write one to clear
          end
        end
        default: ;
      endcase
    end

    // a disabled converter never holds the go bit
    if (!r_next.main_ctl[ACTU_MAIN_ON]) begin
      r_next.main_ctl[ACTU_MAIN_GO] = 1'b0;
    end

    // sequencer
    unique case (r_reg.state)
      ACTU_ST_IDLE: begin
        // go set by software, or the trigger source, starts a cycle
        do_start = r_next.main_ctl[ACTU_MAIN_GO]
                 | (i_trigger & r_next.main_ctl[ACTU_MAIN_ON]);
      end
      ACTU_ST_CONV: begin
        if (!r_next.main_ctl[ACTU_MAIN_GO]) begin
          r_next.state = ACTU_ST_IDLE;         // software abort
        end else if (i_conv_done) begin
          if (dsen && !r_reg.pair_second) begin
            // first of a pair: hold the value, set math, no error, no threshold flag
            r_next.res = smp;
            r_next.pair_second = 1'b1;
            r_next.math = 1'b1;
            r_next.flt = r_reg.acc >> crs;
            go_again = cont;
          end else begin
            if (dsen) begin
              r_next.prev = r_reg.res;
              term = smp - r_reg.res;
            end
            r_next.res = smp;
            r_next.pair_second = 1'b0;
            r_next.math = 1'b1;
            if (mode != ACTU_MD_BASIC) begin
              sum = actu_acc_step(r_reg.acc, term, dsen,
                                  mode == ACTU_MD_LPF, crs);
              r_next.acc = sum[15:0];
              if (sum[16]) begin
                r_next.aov = 1'b1;
              end
              if (r_reg.cnt != ACTU_CNT_MAX) begin
                r_next.cnt = r_reg.cnt + ACTU_CNT_ONE;
              end
              r_next.flt = sum[15:0] >> crs;
            end
            // averaging modes test only once enough samples are in
            test_now = (mode == ACTU_MD_BASIC) || (mode == ACTU_MD_ACCUM)
                     || (r_next.cnt >= r_reg.rpt);
            r_next.err = actu_error(calc, dsen, r_next.res, r_next.prev,
                                    r_next.flt, r_reg.stpt);
            if (test_now) begin
              r_next.uthr = $signed(r_next.err) > $signed(r_reg.uth);
              r_next.lthr = $signed(r_next.err) < $signed(r_reg.lth);
              if (actu_thr_met(tmd, r_next.err, r_reg.lth, r_reg.uth)
                  || r_next.aov) begin
                r_next.tif = 1'b1;
              end
            end
            go_again = (cont && !(soi && r_next.tif))
                     || ((mode == ACTU_MD_BURST) && (r_next.cnt < r_reg.rpt));
          end
          if (go_again) begin
            do_start = 1'b1;
            hw_retrig = 1'b1;
          end else begin
            r_next.main_ctl[ACTU_MAIN_GO] = 1'b0;
            r_next.state = ACTU_ST_IDLE;
          end
        end
      end
      default: r_next.state = ACTU_ST_IDLE;
    endcase

    // start of a conversion cycle
    if (do_start) begin
      r_next.state = ACTU_ST_CONV;
      r_next.main_ctl[ACTU_MAIN_GO] = 1'b1;
      r_next.conv_start = 1'b1;
      // second of a pair takes its previous value at the end instead
      if (!r_next.pair_second) begin
        r_next.prev = r_reg.comp_ctl[ACTU_COMP_PSIS] ? r_next.flt
          : r_next.res;
      end
      // averaging restarts its sum on a fresh cycle
      if (((mode == ACTU_MD_AVG) && (r_next.cnt >= r_reg.rpt))
          || ((mode == ACTU_MD_BURST) && !hw_retrig)) begin
        r_next.acc = ACTU_RST_WORD;
        r_next.cnt = ACTU_RST_BYTE;
        r_next.aov = 1'b0;
      end
    end

    // accumulator clear wins over a sample landing in the same cycle
    if (r_reg.comp_ctl[ACTU_COMP_ACLR]) begin
      r_next.acc = ACTU_RST_WORD;
      r_next.aov = 1'b0;
      r_next.cnt = ACTU_RST_BYTE;
      r_next.comp_ctl[ACTU_COMP_ACLR] = 1'b0;
    end
  end

  // =====================================================================
  // state register
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      r_reg <= '0;
      r_reg.state <= ACTU_ST_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state record
  assign o_rd_data = r_reg.rd_data;
  assign o_conv_start = r_reg.conv_start;
  assign o_conv_busy = r_reg.main_ctl[ACTU_MAIN_GO];
  assign o_channel = r_reg.chan_sel;
  assign o_threshold_flag = r_reg.tif;
  assign o_overflow_flag = r_reg.aov;

endmodule : actu_top

`default_nettype wire

/* File: tb/actu_core_model.sv */
// converter core model answering each start after a set latency
`timescale 1ns/1ps
`default_nettype none
module actu_core_model (
  input wire logic i_clk,         // system clock
  input wire logic i_start,       // start pulse from the block
  input wire logic [9:0] i_value, // value of the next result
  input wire logic [3:0] i_lat,   // cycles from start to done
  output var logic o_done,        // end-of-conversion pulse
  output var logic [9:0] o_result // raw result, valid with done only
);
  int cnt = 0;
  // ===================================================================
  // count down; outside done the result toggles so stale data shows
  always @(posedge i_clk) begin
    o_done <= (cnt == 1);
    o_result <= (cnt == 1) ? i_value : ~o_result;
    if (i_start) begin
      cnt <= int'(i_lat);
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule : actu_core_model
`default_nettype wire

/* File: tb/actu_checker_props.sv */
// assertions on the ports of the compute and threshold unit
`timescale 1ns/1ps
`default_nettype none
module actu_checker
  import actu_pkg::*;
(
  input wire logic i_clk,           // system clock
  input wire logic i_reset_n,       // synchronous reset, active low
  input wire logic [11:0] i_addr,   // register address
  input wire logic [7:0] i_wr_data, // write data
  input wire logic i_wr_en,         // write strobe
  input wire logic i_rd_en,         // read strobe
  input wire logic i_trigger,       // external start
  input wire logic i_conv_done,     // end of conversion
  input wire logic [7:0] o_rd_data, // read data
  input wire logic o_conv_start,    // start pulse
  input wire logic o_conv_busy,     // go bit
  input wire logic o_threshold_flag, // interrupt flag
  input wire logic o_overflow_flag  // overflow flag
);
  // ===================================================================
  // one domain, so clock and reset are given once
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  a_start_one_cycle: assert property (o_conv_start |=>
    !o_conv_start) else $error("start pulse too long");
  a_start_cause: assert property (o_conv_start |->
    $past(i_conv_done || i_trigger ||
    (i_wr_en && i_addr == ACTU_ADR_MAIN_CTL)))
    else $error("start without cause");
  a_start_busy: assert property (o_conv_start |-> o_conv_busy)
    else $error("start without busy");
  a_busy_end: assert property ($fell(o_conv_busy) |->
    $past(i_conv_done || i_wr_en)) else $error("busy fell early");
  a_flag_cause: assert property ($rose(o_threshold_flag) |->
    $past(i_conv_done)) else $error("flag without result");
  a_ovf_cause: assert property ($rose(o_overflow_flag) |->
    $past(i_conv_done)) else $error("overflow without sample");
  a_clear_ovf: assert property (i_addr == ACTU_ADR_COMP_CTL &&
    i_wr_en && i_wr_data[ACTU_COMP_ACLR] |-> ##3 !o_overflow_flag)
    else $error("clear kept overflow");
  a_rd_quiet: assert property (!$past(i_rd_en) |-> o_rd_data == 8'h00)
    else $error("read data outside slot");
endmodule : actu_checker
bind actu_top actu_checker u_chk (.*);
`default_nettype wire

/* File: tb/test_actu_top.sv */
// self-checking bench for the compute and threshold unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; \
  if ((got) !== (ex)) begin failures++; \
  $display("unexpected %s exp %h got %h", nm, ex, got); end end
module test_actu_top;
  import actu_pkg::*;
  logic i_clk = 0, i_reset_n = 0, i_wr_en = 0, i_rd_en = 0, i_trigger = 0;
  logic [11:0] i_addr = 12'h000;
  logic [7:0] i_wr_data = 8'h00, nt;
  logic [9:0] val = 10'h000;
  logic [3:0] lat = 4'h3;
  logic [15:0] e;
  logic rd_d = 1'b0;
  logic [7:0] notes[$];
  wire [7:0] o_rd_data, o_channel;
  wire o_conv_start, o_conv_busy, o_threshold_flag, o_overflow_flag, done;
  wire [9:0] result;
  int failures = 0, n_tests = 0, seed = 9, sum, k;
  localparam logic [7:0] TMD_HIT = 8'hB2; // expected hit per condition code
  actu_top uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .i_trigger(i_trigger), .i_conv_done(done), .i_conv_result(result),
    .o_rd_data(o_rd_data), .o_conv_start(o_conv_start),
    .o_conv_busy(o_conv_busy), .o_channel(o_channel),
    .o_threshold_flag(o_threshold_flag), .o_overflow_flag(o_overflow_flag));
  actu_core_model core (.i_clk(i_clk), .i_start(o_conv_start),
    .i_value(val), .i_lat(lat), .o_done(done), .o_result(result));
  // ===================================================================
  // bus tasks: strobes last one cycle, reads leave a note
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr_en <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_clk);
    i_wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    notes.push_back(x);
    @(posedge i_clk);
    i_rd_en <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd_en <= 1'b0;
  endtask : rd
  task automatic rd16(input logic [11:0] a, input logic [15:0] x);
    rd(a, x[7:0]);
    rd(a + 12'h001, x[15:8]);
  endtask : rd16
  // trigger one conversion and wait a bounded time for busy to drop
  task automatic conv(input logic [9:0] v);
    val <= v;
    @(posedge i_clk);
    i_trigger <= 1'b1;
    @(posedge i_clk);
    i_trigger <= 1'b0;
    for (int i = 0; i < 100; i++) begin
      @(posedge i_clk);
      #1;
      if (o_conv_busy === 1'b0) break;
    end
    `CHK("busy", 1'b0, o_conv_busy)
  endtask : conv
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // read data land one cycle after the strobe; oldest note is compared
  always @(posedge i_clk) begin
    if (rd_d) begin
      nt = notes.pop_front();
      `CHK("read data", nt, o_rd_data)
    end
    rd_d <= i_rd_en;
  end
  initial forever #10 i_clk = ~i_clk;
  initial begin
    #400000;
    failures++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge i_clk);
    i_reset_n <= 1'b1;
    wr(ACTU_ADR_RES_L, 8'h5A); // read-only, ignored
    rd(ACTU_ADR_RES_L, 8'h00);
    rd(12'hF00, 8'h00);
    k = $random(seed);
    wr(ACTU_ADR_CHAN_SEL, 8'(k));
    wr(ACTU_ADR_MAIN_CTL, 8'h84); // enabled, right justified
    `CHK("channel", 8'(k), o_channel)
    // average of four random samples; test due only on the fourth
    wr(ACTU_ADR_RPT, 8'h04);
    wr(ACTU_ADR_COMP_CTL, 8'h22);
    wr(ACTU_ADR_THR_CTL, 8'h77);
    sum = 0;
    for (k = 1; k <= 4; k++) begin
      e = 16'($random(seed) & 32'h3FF);
      sum += int'(e);
      conv(e[9:0]);
      rd(ACTU_ADR_CNT, 8'(k));
      rd16(ACTU_ADR_FLT_L, 16'(sum >> 2));
      rd(ACTU_ADR_IRQ_FLAG, {7'h00, k == 4});
    end
    rd16(ACTU_ADR_ERR_L, 16'(sum >> 2));
    // result below setpoint gives a negative error; every condition
    wr(ACTU_ADR_COMP_CTL, 8'h00);
    wr(ACTU_ADR_STPT_H, 8'h02);
    wr(ACTU_ADR_LTH_L, 8'h80);
    wr(ACTU_ADR_LTH_H, 8'hFF);
    wr(ACTU_ADR_UTH_L, 8'h10);
    for (k = 0; k < 8; k++) begin
      wr(ACTU_ADR_IRQ_FLAG, 8'h01);
      wr(ACTU_ADR_THR_CTL, 8'h10 | 8'(k));
      conv(10'h100);
      rd(ACTU_ADR_IRQ_FLAG, {7'h00, TMD_HIT[k]});
    end
    rd16(ACTU_ADR_ERR_L, 16'hFF00);
    rd(ACTU_ADR_STATUS, 8'h31);
    // long accumulation: overflow, forced interrupt, saturation, clear
    wr(ACTU_ADR_THR_CTL, 8'h00);
    wr(ACTU_ADR_IRQ_FLAG, 8'h01);
    wr(ACTU_ADR_COMP_CTL, 8'h09);
    for (k = 1; k <= 257; k++) begin
      conv(10'h3FF);
      if (k == 64 || k == 65)
        `CHK("overflow", k == 65, o_overflow_flag)
    end
    rd(ACTU_ADR_CNT, 8'hFF);
    rd(ACTU_ADR_IRQ_FLAG, 8'h01);
    wr(ACTU_ADR_COMP_CTL, 8'h09);
    rd(ACTU_ADR_CNT, 8'h00);
    rd16(ACTU_ADR_ACC_L, 16'h0000);
    `CHK("overflow", 1'b0, o_overflow_flag)
    // one start, slow core: burst runs four samples by itself
    wr(ACTU_ADR_COMP_CTL, 8'h23);
    lat <= 4'h6;
    conv(10'h005);
    rd(ACTU_ADR_CNT, 8'h04);
    rd16(ACTU_ADR_ACC_L, 16'h0014);
    // pair: first half gives no interrupt, second gives the difference
    wr(ACTU_ADR_COMP_CTL, 8'h14);
    wr(ACTU_ADR_SAMP_CTL1, 8'h01);
    wr(ACTU_ADR_THR_CTL, 8'h07);
    wr(ACTU_ADR_IRQ_FLAG, 8'h01);
    conv(10'h064);
    rd(ACTU_ADR_IRQ_FLAG, 8'h00);
    conv(10'h12C);
    rd16(ACTU_ADR_PREV_L, 16'h0064);
    rd16(ACTU_ADR_ERR_L, 16'h00C8);
    rd(ACTU_ADR_IRQ_FLAG, 8'h01);
    repeat (2) @(posedge i_clk);
    final_report();
  end
endmodule : test_actu_top
`default_nettype wire
